/* File: edge_irq_pkg.sv */
// package: constants and types for the edge interrupt input unit
package edge_irq_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned NUM_INPUTS  = 6;
  localparam int unsigned LABEL_W     = 16;
  localparam int unsigned IDX_W       = 3;
  localparam int unsigned GRP_G       = 4;
  localparam int unsigned GRP_H       = 5;
  localparam logic [5:0]  ALL_ZERO6   = 6'h00;
  localparam logic [5:0]  ALL_ONE6    = 6'h3F;
  localparam logic [LABEL_W-1:0] LABEL_RESET = 16'h0000;
  localparam logic [IDX_W-1:0]   IDX_RESET   = 3'h0;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_sel_e;

  typedef enum logic [1:0] {
    MODE_INTERRUPT,
    MODE_NORMAL,
    MODE_COUNTER,
    MODE_CATCH
  } grp_mode_e;

  typedef enum logic {
    ST_IDLE,
    ST_SERVICE
  } svc_state_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    grp_mode_e mode;
    edge_sel_e edge_sel;
  } grp_cfg_s;

  typedef struct packed {
    logic                 valid;
    logic [IDX_W-1:0]     group;
    logic [LABEL_W-1:0]   label;
  } vector_s;

endpackage : edge_irq_pkg

/* File: edge_interrupt_input_unit.sv */
// edge interrupt input unit: six edge-triggered inputs vectoring the sequencer
//
// Behaviour
// - Six inputs in_a, in_c, in_d, in_f, in_g and in_h can each be chosen as an interrupt source.
// - Each input holds an edge choice of rising only, falling only or both edges.
// - With rising selected the interrupt fires when the input goes from off to on.
// - With falling selected the interrupt fires when the input goes from on to off.
// - With both selected the interrupt fires on every transition of the input.
// - An interrupt diverts execution at once to the label held in that input's jump target, not at end of scan.
// - Groups 1 to 6 map in order to in_a, in_c, in_d, in_f, in_g and in_h for jump targets and status flags.
// - Each group selects exactly one of interrupt, normal, counter or catch function.
// - Inputs in normal mode are sampled only when the end-of-scan instruction runs.
// - in_g and in_h may interrupt only on the 24, 40 and 48 point variants, never on the 12 point one.
// - Each interrupt input is enabled or disabled on its own, enabled by default, and its status reads on while enabled.
// - Simultaneous requests are served in order in_a, in_c, in_d, in_f, in_g, then in_h.
// - Service never nests; a request during a routine waits pending until that routine ends.
`timescale 1ns/1ps

module edge_interrupt_input_unit
  import edge_irq_pkg::*;
(
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              resetn,
  // field inputs, group order a c d f g h
  input  wire logic [NUM_INPUTS-1:0]             in_pins,
  // configuration, grp_cfg captured on program load, variant_12pt used as it stands
  input  wire logic                              program_load,
  input  wire grp_cfg_s [NUM_INPUTS-1:0]         grp_cfg,
  input  wire logic                              variant_12pt,
  // enable and disable per input
  input  wire logic [NUM_INPUTS-1:0]             irq_enable_set,
  input  wire logic [NUM_INPUTS-1:0]             irq_disable_set,
  // jump targets
  input  wire logic [LABEL_W-1:0]                jump_target_a,
  input  wire logic [LABEL_W-1:0]                jump_target_c,
  input  wire logic [LABEL_W-1:0]                jump_target_d,
  input  wire logic [LABEL_W-1:0]                jump_target_f,
  input  wire logic [LABEL_W-1:0]                jump_target_g,
  input  wire logic [LABEL_W-1:0]                jump_target_h,
  // sequencer
  input  wire logic                              end_of_scan,
  input  wire logic                              vector_ack,
  input  wire logic                              routine_done,
  output vector_s                                vector,
  output logic                                   in_service,
  output logic [NUM_INPUTS-1:0]                  normal_image,
  output logic [NUM_INPUTS-1:0]                  pending,
  // status flags
  output logic                                   irq_status_a,
  output logic                                   irq_status_c,
  output logic                                   irq_status_d,
  output logic                                   irq_status_f,
  output logic                                   irq_status_g,
  output logic                                   irq_status_h
);

  // ****************************************
  // synchroniser and edge detection
  // ****************************************
  logic [NUM_INPUTS-1:0] meta_q, meta_d;
  logic [NUM_INPUTS-1:0] sync_q, sync_d;
  logic [NUM_INPUTS-1:0] prev_q, prev_d;
  logic [NUM_INPUTS-1:0] rise, fall, fire;
  logic [NUM_INPUTS-1:0] allowed;
  grp_cfg_s [NUM_INPUTS-1:0] cfg_q, cfg_d;
  logic [NUM_INPUTS-1:0]     en_q, en_d;
  logic [NUM_INPUTS-1:0]     image_q, image_d;

  always_comb begin
    // pins pass two flops before any logic reads them
    meta_d = in_pins;
    sync_d = meta_q;
    prev_d = sync_q;
    rise   = sync_q & ~prev_q;
    fall   = ~sync_q & prev_q;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      allowed[i] = (cfg_q[i].mode == MODE_INTERRUPT) && en_q[i];
      // small variant keeps groups g and h off
      if ((i == GRP_G || i == GRP_H) && variant_12pt) begin
        allowed[i] = 1'b0;
      end
      case (cfg_q[i].edge_sel)
        EDGE_RISE: fire[i] = allowed[i] & rise[i];
        EDGE_FALL: fire[i] = allowed[i] & fall[i];
        EDGE_BOTH: fire[i] = allowed[i] & (rise[i] | fall[i]);
        default:   fire[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= ALL_ZERO6;
      sync_q <= ALL_ZERO6;
      prev_q <= ALL_ZERO6;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // ****************************************
  // configuration and enables
  // ****************************************

  always_comb begin
    cfg_d = cfg_q;
    if (program_load) begin
      cfg_d = grp_cfg;
    end
    en_d = (en_q | irq_enable_set) & ~irq_disable_set;
    // a program load re-enables every input
    if (program_load) begin
      en_d = ALL_ONE6;
    end
    image_d = image_q;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (end_of_scan && cfg_q[i].mode == MODE_NORMAL) begin
        image_d[i] = sync_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        cfg_q[i].mode     <= MODE_NORMAL;
        cfg_q[i].edge_sel <= EDGE_RISE;
      end
      en_q    <= ALL_ONE6;
      image_q <= ALL_ZERO6;
    end else begin
      cfg_q   <= cfg_d;
      en_q    <= en_d;
      image_q <= image_d;
    end
  end

  assign normal_image = image_q;
  assign irq_status_a = en_q[0];
  assign irq_status_c = en_q[1];
  assign irq_status_d = en_q[2];
  assign irq_status_f = en_q[3];
  assign irq_status_g = en_q[4];
  assign irq_status_h = en_q[5];

  // ****************************************
  // pending, priority and service
  // ****************************************
  logic [NUM_INPUTS-1:0]  pend_q, pend_d;
  logic [LABEL_W-1:0]     targets [NUM_INPUTS];
  svc_state_e             state_q, state_d;
  vector_s                vec_q, vec_d;
  logic                   found;
  logic [IDX_W-1:0]       pick;

  always_comb begin
    targets[0] = jump_target_a;
    targets[1] = jump_target_c;
    targets[2] = jump_target_d;
    targets[3] = jump_target_f;
    targets[4] = jump_target_g;
    targets[5] = jump_target_h;
    found = 1'b0;
    pick  = IDX_RESET;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        found = 1'b1;
        pick  = IDX_W'(i);
      end
    end
    pend_d  = pend_q;
    state_d = state_q;
    vec_d   = vec_q;
    case (state_q)
      ST_IDLE: begin
        if (vec_q.valid && vector_ack) begin
          pend_d[vec_q.group] = 1'b0;
          vec_d.valid         = 1'b0;
          state_d             = ST_SERVICE;
        end else if (found && !vec_q.valid) begin
          // a waiting vector stays fixed until it is taken
          vec_d.valid = 1'b1;
          vec_d.group = pick;
          vec_d.label = targets[pick];
        end
      end
      ST_SERVICE: begin
        // no new vector until the routine ends
        if (routine_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // a fresh edge wins over a clear in the same cycle
    pend_d = pend_d | fire;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q      <= ALL_ZERO6;
      state_q     <= ST_IDLE;
      vec_q.valid <= 1'b0;
      vec_q.group <= IDX_RESET;
      vec_q.label <= LABEL_RESET;
    end else begin
      pend_q  <= pend_d;
      state_q <= state_d;
      vec_q   <= vec_d;
    end
  end

  assign vector     = vec_q;
  assign in_service = (state_q == ST_SERVICE);
  assign pending    = pend_q;

endmodule // edge_interrupt_input_unit

/* File: eiu_props.sv */
// checker: port-level properties of the edge interrupt unit
`timescale 1ns/1ps
module eiu_props
  import edge_irq_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // control
  input wire logic        program_load,
  input wire logic        variant_12pt,
  input wire logic [5:0]  irq_disable_set,
  input wire logic [15:0] jump_target_a,
  input wire logic        vector_ack,
  input wire logic        routine_done,
  // results
  input wire vector_s     vector,
  input wire logic        in_service,
  input wire logic [5:0]  pending,
  input wire logic        irq_status_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_no_nest: assert property (in_service |-> !vector.valid) else $error("vector in service");
  a_ack_enter: assert property (vector.valid && vector_ack && !in_service |=> in_service && !vector.valid)
    else $error("ack not taken");
  a_done_leave: assert property (in_service && routine_done |=> !in_service) else $error("done not taken");
  a_vec_hold: assert property (vector.valid && !vector_ack |=> vector.valid && $stable(vector))
    else $error("vector moved");
  a_label_map: assert property (vector.valid && vector.group == 3'h0 |-> vector.label == jump_target_a)
    else $error("wrong label");
  a_prio_order: assert property ($rose(vector.valid) |->
    ($past(pending) & ~(6'h3e << vector.group)) == (6'h01 << vector.group)) else $error("priority");
  a_small_var: assert property (variant_12pt && $rose(vector.valid) |-> vector.group < GRP_G)
    else $error("g or h on small variant");
  a_load_en: assert property (program_load && !irq_disable_set[0] |=> irq_status_a) else $error("load enable");
  a_dis_clear: assert property (irq_disable_set[0] && !program_load |=> !irq_status_a) else $error("disable");
endmodule // eiu_props

bind edge_interrupt_input_unit eiu_props i_eiu_props (.*);

/* File: field_wiring.sv */
// field model: external wiring driving the input terminals
`timescale 1ns/1ps
module field_wiring (
  // clock
  input wire logic       clk,
  // requested levels and terminals
  input wire logic [5:0] level,
  output logic [5:0]     in_pins
);
  initial in_pins = 6'h00;
  // levels move just after an edge and are held for many clocks
  always @(posedge clk) in_pins <= #1 level;
endmodule // field_wiring

/* File: edge_interrupt_input_unit_tb.sv */
// testbench: edge interrupt unit against field wiring and a random sequencer
`timescale 1ns/1ps
module edge_interrupt_input_unit_tb import edge_irq_pkg::*; ;
  logic clk = 0, resetn = 0, program_load = 0, variant_12pt = 0;
  logic end_of_scan = 0, vector_ack = 0, routine_done = 0, in_service;
  logic [5:0] level = 0, dis = 0, ena = 0, in_pins, pend, nimg, img;
  wire [5:0] st;
  grp_cfg_s [5:0] cfg = '0;
  logic [15:0] jt [6];
  vector_s vector;
  logic [18:0] q [$];
  int n_fail = 0, comparisons = 0, cyc = 0;

  field_wiring i_field_wiring (.clk(clk), .level(level), .in_pins(in_pins));
  edge_interrupt_input_unit i_edge_interrupt_input_unit (.clk(clk), .resetn(resetn), .in_pins(in_pins),
    .program_load(program_load), .grp_cfg(cfg), .variant_12pt(variant_12pt), .irq_enable_set(ena),
    .irq_disable_set(dis), .jump_target_a(jt[0]), .jump_target_c(jt[1]), .jump_target_d(jt[2]),
    .jump_target_f(jt[3]), .jump_target_g(jt[4]), .jump_target_h(jt[5]), .end_of_scan(end_of_scan),
    .vector_ack(vector_ack), .routine_done(routine_done), .vector(vector), .in_service(in_service),
    .normal_image(nimg), .pending(pend), .irq_status_a(st[0]), .irq_status_c(st[1]), .irq_status_d(st[2]),
    .irq_status_f(st[3]), .irq_status_g(st[4]), .irq_status_h(st[5]));

  initial forever #5 clk = ~clk;

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(string what, logic [18:0] exp, logic [18:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic load(grp_mode_e m);
    foreach (cfg[i]) cfg[i] = '{m, edge_sel_e'(i % 3)};
    program_load = 1;
    tick(1);
    program_load = 0;
  endtask

  // note the groups expected to vector, in service order, then move the pins
  task automatic fire(logic [5:0] lv, logic [5:0] grp);
    for (int g = 0; g < 6; g++) if (grp[g]) q.push_back({3'(g), jt[g]});
    level = lv;
    tick(150);
    chk("left", 19'h0, 19'(q.size()));
    chk("pending", 19'h0, 19'(pend));
  endtask

  // sequencer: random ack and routine length
  always @(posedge clk) begin
    #1;
    vector_ack = vector.valid && !in_service && $urandom_range(1);
    routine_done = in_service && ($urandom_range(2) == 0);
  end

  always @(posedge clk) begin
    if (vector.valid && vector_ack && !in_service)
      chk("vector", q.size() ? q.pop_front() : 19'h7_ffff, {vector.group, vector.label});
    if (++cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hd284));
    foreach (jt[i]) jt[i] = 16'($urandom);
    tick(3);
    resetn = 1;
    chk("status", 19'h3f, 19'(st));
    load(MODE_INTERRUPT);
    fire(6'h3f, 6'h2d);
    fire(6'h00, 6'h36);
    variant_12pt = 1;
    fire(6'h3f, 6'h0d);
    fire(6'h00, 6'h06);
    variant_12pt = 0;
    dis = 6'h01;
    tick(1);
    dis = 0;
    chk("status", 19'h3e, 19'(st));
    fire(6'h3f, 6'h2c);
    ena = 6'h01;
    tick(1);
    ena = 0;
    chk("status", 19'h3f, 19'(st));
    fire(6'h00, 6'h36);
    fire(6'h3f, 6'h2d);
    load(MODE_NORMAL);
    for (int k = 0; k < 4; k++) begin
      level = 6'($urandom);
      tick(4);
      if (k > 0) chk("image", 19'(img), 19'(nimg));
      end_of_scan = 1;
      tick(1);
      end_of_scan = 0;
      img = level;
      chk("image", 19'(img), 19'(nimg));
    end
    load(MODE_CATCH);
    fire(~level, 6'h00);
    end_of_scan = 1;
    tick(1);
    end_of_scan = 0;
    chk("image", 19'(img), 19'(nimg));
    tick(20);
    close_out();
  end
endmodule // edge_interrupt_input_unit_tb
